// >>> dfm_chk_sva.sv
// port checker for the dual frequency monitor
`timescale 1ns/1ps
module dfm_chk #(
  parameter TICK_CYC = 20
) (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // monitor
  input wire [1:0] freq_in,
  input wire [1:0] chan_enable,
  input wire [1:0] chan_error,
  input wire [1:0] chan_stuck,
  input wire fault_present
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  int lo0 = 0;
  int lo1 = 0;
  int hi0 = 0;
  // saturating run lengths of the raw input levels
  always @(posedge sys_clk)
  begin
    lo0 <= freq_in[0] ? 0 : (lo0 < 100000 ? lo0 + 1 : lo0);
    lo1 <= freq_in[1] ? 0 : (lo1 < 100000 ? lo1 + 1 : lo1);
    hi0 <= !freq_in[0] ? 0 : (hi0 < 100000 ? hi0 + 1 : hi0);
  end
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_resp;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("request not acked next cycle");
  property p_dat_hold;
    $changed(wb_dat_o) |-> wb_ack_o;
  endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data changed without ack");
  property p_fp_src;
    fault_present |-> $past(|{chan_error, chan_stuck});
  endproperty
  a_fp_src: assert property (p_fp_src) else $error("summary fault without cause");
  property p_stk_clr0;
    lo0 == TICK_CYC + 6 |-> !chan_stuck[0];
  endproperty
  a_stk_clr0: assert property (p_stk_clr0) else $error("stuck 1 stays after low");
  property p_stk_clr1;
    lo1 == TICK_CYC + 6 |-> !chan_stuck[1];
  endproperty
  a_stk_clr1: assert property (p_stk_clr1) else $error("stuck 2 stays after low");
  property p_stk_set;
    $rose(chan_stuck[0]) |-> hi0 > 7 * TICK_CYC;
  endproperty
  a_stk_set: assert property (p_stk_set) else $error("stuck 1 set too early");
  property p_en_err;
    $rose(chan_enable[0]) |-> ##[0:1] !chan_error[0];
  endproperty
  a_en_err: assert property (p_en_err) else $error("error 1 kept after enable");
  property p_en_stk;
    chan_stuck[0] |-> !chan_enable[0];
  endproperty
  a_en_stk: assert property (p_en_stk) else $error("enable 1 with stuck input");
endmodule

bind dfm_top dfm_chk #(.TICK_CYC(TICK_CYC)) u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .freq_in(freq_in), .chan_enable(chan_enable), .chan_error(chan_error),
  .chan_stuck(chan_stuck), .fault_present(fault_present));

// >>> dfm_pulse_src.sv
// pulse source model standing in for an encoder on one monitor input
`timescale 1ns/1ps
module dfm_pulse_src (
  // clock
  input wire logic clk,
  // shape in clock cycles; a zero period holds the line high
  input wire logic [15:0] per,
  input wire logic [15:0] hi,
  // pulse line
  output logic pulse
);
  logic [15:0] cnt = 16'h0000;
  initial pulse = 1'b0;
  always @(posedge clk)
  begin
    cnt <= (cnt + 16'h0001 >= per) ? 16'h0000 : cnt + 16'h0001;
    pulse <= (per == 16'h0000) || (cnt < hi);
  end
endmodule

// >>> dfm_regs.vh
// register offsets, field positions, reset values and timing constants of the frequency monitor
`ifndef DFM_REGS_VH
`define DFM_REGS_VH

// register byte offsets
`define DFM_CTRL_OFS 8'h00
`define DFM_CFG1_OFS 8'h04
`define DFM_CFG2_OFS 8'h08
`define DFM_STAT_OFS 8'h0C

// control fields
`define DFM_CTRL_RUN 0
`define DFM_CTRL_FP_EN 1
`define DFM_CTRL_MODE1 2
`define DFM_CTRL_MODE2 3
`define DFM_CTRL_RST 32'h00000000

// channel configuration fields, all in 10 ms units
`define DFM_CFG_MIN_LO 0
`define DFM_CFG_MAX_LO 8
`define DFM_CFG_NOM_LO 16
`define DFM_CFG_TOL_LO 24
`define DFM_CFG_RST 32'h0000FF02

// status fields
`define DFM_STAT_EN_LO 0
`define DFM_STAT_ERR_LO 2
`define DFM_STAT_STK_LO 4
`define DFM_STAT_FP 6

// timing
`define DFM_EXEC_MS 4
`define DFM_UNIT_MS 10
`define DFM_CYC_PER_MS 100000

`endif

// >>> dfm_top.v
// dual frequency monitor with a classic wishbone register slave
//
// Summary of operation
// - constant high input flagged within max plus cycle
// - two separate channels, each own input, outputs
// - period too short, armed at first rise
// - period too long, armed at first rise
// - pulse too short when nominal is nonzero
// - pulse too long without falling edge
// - stuck high armed immediately on run
// - enable after two valid periods and pulses
// - zero nominal treats pulse as valid
// - enable drops on any active fault
// - all errors mode reports every fault
// - stuck only mode reports stuck high
// - stuck output follows constant high, clears low
// - fault present ors errors and stucks
// - error clears when enable rises
// - stop to run clears all outputs
// - each period judged alone, counters restart at every rise
// - one shared option enables fault present
//
// The placing of the registers and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "dfm_regs.vh"

module dfm_top #(
  parameter TICK_CYC = `DFM_EXEC_MS * `DFM_CYC_PER_MS
) (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // pulse inputs
  input wire [1:0] freq_in,
  // monitor outputs
  output wire [1:0] chan_enable,
  output wire [1:0] chan_error,
  output wire [1:0] chan_stuck,
  output reg fault_present
);

  localparam [19:0] TICK_LAST = TICK_CYC - 1;
  localparam [11:0] STEP = `DFM_EXEC_MS;
  localparam [11:0] UNIT = `DFM_UNIT_MS;
  localparam [11:0] CNT_MAX = 12'hFFF;

  reg [31:0] ctrl_reg;
  reg [31:0] cfg_reg [0:1];
  reg run_d_reg;
  reg [19:0] tick_cnt_reg;
  reg tick_reg;
  wire run;
  wire run_start;
  wire clear;
  wire wb_req;
  wire [31:0] stat_word;
  wire [31:0] wmask;
  integer i;

  assign run = ctrl_reg[`DFM_CTRL_RUN];
  assign run_start = run & ~run_d_reg;
  assign clear = ~run | run_start;
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign stat_word = {25'h0000000, fault_present, chan_stuck, chan_error, chan_enable};

  // register slave, one wait state, unmapped reads give zero
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg <= `DFM_CTRL_RST;
      cfg_reg[0] <= `DFM_CFG_RST;
      cfg_reg[1] <= `DFM_CFG_RST;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      if (wb_req && wb_we_i)
      begin
        case (wb_adr_i)
          `DFM_CTRL_OFS: ctrl_reg <= (ctrl_reg & ~wmask) | (wb_dat_i & wmask & 32'h0000000F);
          `DFM_CFG1_OFS: cfg_reg[0] <= (cfg_reg[0] & ~wmask) | (wb_dat_i & wmask);
          `DFM_CFG2_OFS: cfg_reg[1] <= (cfg_reg[1] & ~wmask) | (wb_dat_i & wmask);
          default: ;
        endcase
      end
      if (wb_req && !wb_we_i)
      begin
        case (wb_adr_i)
          `DFM_CTRL_OFS: wb_dat_o <= ctrl_reg;
          `DFM_CFG1_OFS: wb_dat_o <= cfg_reg[0];
          `DFM_CFG2_OFS: wb_dat_o <= cfg_reg[1];
          `DFM_STAT_OFS: wb_dat_o <= stat_word;
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // logic execution cycle tick, restarted at run entry
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_d_reg <= 1'b0;
      tick_cnt_reg <= 20'h00000;
      tick_reg <= 1'b0;
    end
    else
    begin
      run_d_reg <= run;
      if (clear || tick_cnt_reg == TICK_LAST)
        tick_cnt_reg <= 20'h00000;
      else
        tick_cnt_reg <= tick_cnt_reg + 20'h00001;
      tick_reg <= ~clear && (tick_cnt_reg == TICK_LAST);
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : ch
      reg sync1_reg;
      reg sync2_reg;
      reg smp_reg;
      reg armed_reg;
      reg pulse_ok_reg;
      reg [11:0] per_cnt_reg;
      reg [11:0] hi_cnt_reg;
      reg [11:0] stk_cnt_reg;
      reg [1:0] good_reg;
      reg en_reg;
      reg err_reg;
      reg stk_reg;
      wire [11:0] min10;
      wire [11:0] max10;
      wire [11:0] nom10;
      wire [11:0] tol10;
      wire [11:0] plo;
      wire [11:0] phi;
      wire pact;
      wire stuck_mode;
      wire rise;
      wire fall;
      wire [11:0] per_nx;
      wire [11:0] hi_nx;
      wire [11:0] stk_nx;
      wire f_short;
      wire f_long;
      wire f_pshort;
      wire f_plong;
      wire fault;
      wire stk_next;
      wire pulse_good;
      wire en_up;
      wire err_set;

      assign min10 = {4'h0, cfg_reg[g][`DFM_CFG_MIN_LO +: 8]} * UNIT;
      assign max10 = {4'h0, cfg_reg[g][`DFM_CFG_MAX_LO +: 8]} * UNIT;
      assign nom10 = {4'h0, cfg_reg[g][`DFM_CFG_NOM_LO +: 8]} * UNIT;
      assign tol10 = {7'h00, cfg_reg[g][`DFM_CFG_TOL_LO +: 5]} * UNIT;
      assign plo = (tol10 > nom10) ? 12'h000 : nom10 - tol10;
      assign phi = nom10 + tol10;
      assign pact = (nom10 != 12'h000);
      assign stuck_mode = ctrl_reg[`DFM_CTRL_MODE1 + g];

      assign rise = sync2_reg & ~smp_reg;
      assign fall = ~sync2_reg & smp_reg;
      // saturating counters advance one execution time per tick
      assign per_nx = (per_cnt_reg > CNT_MAX - STEP) ? CNT_MAX : per_cnt_reg + STEP;
      assign hi_nx = (hi_cnt_reg > CNT_MAX - STEP) ? CNT_MAX : hi_cnt_reg + STEP;
      assign stk_nx = (stk_cnt_reg > CNT_MAX - STEP) ? CNT_MAX : stk_cnt_reg + STEP;

      assign f_short = armed_reg & rise & (per_nx < min10);
      assign f_long = armed_reg & (per_nx > max10);
      assign f_pshort = pact & armed_reg & fall & (hi_nx < plo);
      assign f_plong = pact & armed_reg & sync2_reg & smp_reg & (hi_nx > phi);
      assign fault = f_short | f_long | f_pshort | f_plong;
      assign stk_next = sync2_reg & (stk_reg | (stk_nx > max10));
      assign pulse_good = ~pact | pulse_ok_reg;
      assign en_up = ~fault & rise & armed_reg & pulse_good & (good_reg == 2'h1) & ~en_reg;
      assign err_set = stuck_mode ? stk_next : (fault | stk_next);

      always @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          sync1_reg <= 1'b0;
          sync2_reg <= 1'b0;
        end
        else
        begin
          sync1_reg <= freq_in[g];
          sync2_reg <= sync1_reg;
        end
      end

      always @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          smp_reg <= 1'b0;
          armed_reg <= 1'b0;
          pulse_ok_reg <= 1'b0;
          per_cnt_reg <= 12'h000;
          hi_cnt_reg <= 12'h000;
          stk_cnt_reg <= 12'h000;
          good_reg <= 2'h0;
          en_reg <= 1'b0;
          err_reg <= 1'b0;
          stk_reg <= 1'b0;
        end
        else if (clear)
        begin
          smp_reg <= sync2_reg;
          armed_reg <= 1'b0;
          pulse_ok_reg <= 1'b0;
          per_cnt_reg <= 12'h000;
          hi_cnt_reg <= 12'h000;
          stk_cnt_reg <= 12'h000;
          good_reg <= 2'h0;
          en_reg <= 1'b0;
          err_reg <= 1'b0;
          stk_reg <= 1'b0;
        end
        else if (tick_reg)
        begin
          smp_reg <= sync2_reg;
          if (rise)
          begin
            armed_reg <= 1'b1;
            per_cnt_reg <= 12'h000;
            hi_cnt_reg <= 12'h000;
            pulse_ok_reg <= 1'b0;
          end
          else
          begin
            per_cnt_reg <= per_nx;
            hi_cnt_reg <= sync2_reg ? hi_nx : hi_cnt_reg;
          end
          if (fall)
            pulse_ok_reg <= ~pact | ((hi_nx >= plo) & (hi_nx <= phi));
          stk_cnt_reg <= sync2_reg ? stk_nx : 12'h000;
          stk_reg <= stk_next;
          if (fault)
          begin
            good_reg <= 2'h0;
            en_reg <= 1'b0;
          end
          else if (rise && armed_reg)
          begin
            if (!pulse_good)
              good_reg <= 2'h0;
            else if (good_reg != 2'h2)
              good_reg <= good_reg + 2'h1;
            if (en_up)
              en_reg <= 1'b1;
          end
          if (stuck_mode)
            err_reg <= stk_next;
          else if (err_set)
            err_reg <= 1'b1;
          else if (en_up)
            err_reg <= 1'b0;
        end
      end

      assign chan_enable[g] = en_reg;
      assign chan_error[g] = err_reg;
      assign chan_stuck[g] = stk_reg;
    end
  endgenerate

  // summary output, present only when the shared option is set
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      fault_present <= 1'b0;
    else if (clear)
      fault_present <= 1'b0;
    else
      fault_present <= ctrl_reg[`DFM_CTRL_FP_EN] & (|chan_error | |chan_stuck);
  end

  always @*
  begin
    for (i = 0; i < 1; i = i + 1)
    begin
    end
  end

endmodule

// >>> dfm_top_tb.sv
// self-checking bench for the dual frequency monitor
`timescale 1ns/1ps
`include "dfm_regs.vh"
module dfm_top_tb;
  typedef struct {logic [31:0] ctrl, cfg; logic [15:0] p1, h1, p2, h2; logic [6:0] st;} dfm_row_t;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h00000000, rd;
  logic [31:0] dat_o;
  logic ack, fp;
  logic [1:0] fin, en, err, stk;
  logic [15:0] p1 = 16'h0320, h1 = 16'h0190, p2 = 16'h0320, h2 = 16'h0190;
  int error_cnt = 0;
  int n_compared = 0;
  dfm_row_t rows [10] = '{
    '{32'h3, 32'h0000140A, 800, 400, 800, 400, 7'h03},
    '{32'h3, 32'h0000140A, 800, 400, 300, 150, 7'h49},
    '{32'h3, 32'h0000140A, 1200, 600, 1200, 600, 7'h4C},
    '{32'h3, 32'h0105140A, 800, 250, 800, 250, 7'h03},
    '{32'h3, 32'h0105140A, 800, 100, 800, 100, 7'h4C},
    '{32'h3, 32'h0105140A, 800, 500, 800, 500, 7'h4C},
    '{32'h3, 32'h0000140A, 0, 0, 0, 0, 7'h7C},
    '{32'hF, 32'h0000140A, 300, 150, 300, 150, 7'h00},
    '{32'hF, 32'h0000140A, 0, 0, 0, 0, 7'h7C},
    '{32'h1, 32'h0000140A, 300, 150, 300, 150, 7'h0C}};
  always #5 sys_clk = ~sys_clk;
  dfm_pulse_src src1 (.clk(sys_clk), .per(p1), .hi(h1), .pulse(fin[0]));
  dfm_pulse_src src2 (.clk(sys_clk), .per(p2), .hi(h2), .pulse(fin[1]));
  dfm_top #(.TICK_CYC(20)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .freq_in(fin), .chan_enable(en),
    .chan_error(err), .chan_stuck(stk), .fault_present(fp));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (ack !== 1'b1 && n < 100);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 100)
      error_cnt++;
  endtask
  task automatic close_out();
    if (error_cnt == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic shape(input logic [15:0] a, b, c, d);
    p1 <= a;
    h1 <= b;
    p2 <= c;
    h2 <= d;
  endtask
  initial
  begin
    repeat (80000) @(posedge sys_clk);
    error_cnt++;
    close_out();
  end
  initial
  begin
    logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
    logic [31:0] rv [5] = '{32'h0, 32'h0000FF02, 32'h0000FF02, 32'h0, 32'h0};
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    wb(1'b1, 8'h10, 32'hFFFFFFFF);
    wb(1'b1, 8'h0C, 32'hFFFFFFFF);
    wb(1'b1, 8'h00, 32'hFFFFFFF0);
    for (int i = 0; i < 5; i++)
    begin
      wb(1'b0, ra[i], 32'h0);
      chk("reset reg", rd, rv[i]);
    end
    foreach (rows[i])
    begin
      wb(1'b1, 8'h00, 32'h0);
      wb(1'b1, 8'h04, rows[i].cfg);
      wb(1'b1, 8'h08, rows[i].cfg);
      shape(rows[i].p1, rows[i].h1, rows[i].p2, rows[i].h2);
      wb(1'b1, 8'h00, rows[i].ctrl);
      repeat (5000) @(posedge sys_clk);
      wb(1'b0, 8'h0C, 32'h0);
      chk("status", rd, {25'h0, rows[i].st});
      chk("ports", {25'h0, fp, stk, err, en}, {25'h0, rows[i].st});
    end
    shape(800, 400, 800, 400);
    repeat (5000) @(posedge sys_clk);
    chk("error cleared", {25'h0, fp, stk, err, en}, 32'h03);
    shape(0, 0, 0, 0);
    wb(1'b1, 8'h00, 32'h3);
    repeat (2000) @(posedge sys_clk);
    chk("stuck seen", {30'h0, stk}, 32'h3);
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b1, 8'h00, 32'h3);
    repeat (2) @(posedge sys_clk);
    chk("run clears", {25'h0, fp, stk, err, en}, 32'h0);
    close_out();
  end
endmodule
